// *** logic/paof_pin_cell.sv ***
/*
 One pin cell: merges ordinary direction, value and pull-up with the
 override signals of the alternate functions.
 Assumes override signals are already combined per pin by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module paof_pin_cell
	import paof_pkg::*;
(
	input wire logic dir_i,
	input wire logic outval_i,
	input wire logic pud_i,
	input wire logic pullup_override_en_i,
	input wire logic pullup_override_val_i,
	input wire logic ddoe_i,
	input wire logic ddov_i,
	input wire logic pvoe_i,
	input wire logic pvov_i,
	output logic drive_en_o,
	output logic drive_val_o,
	output logic pullup_o
);
	wire logic dir_eff;
	wire logic normal_pu;
	assign dir_eff = ddoe_i ? ddov_i : dir_i;
	assign drive_en_o = dir_eff;
	assign drive_val_o = pvoe_i ? pvov_i : outval_i;
	assign normal_pu = ~dir_i & outval_i & ~pud_i;
	assign pullup_o = pullup_override_en_i ? pullup_override_val_i : normal_pu;
endmodule
`default_nettype wire

// *** logic/paof_pkg.sv ***
/*
 Constants for the port A alternate function override block: pin
 positions of each alternate function and reset values.
 Assumes one synchronous clock domain; no register bus.
*/
// Operation
// - SPI slave forces bit 6 input
// - Slave SPI active only while select low
// - Bit 6 pull-up follows its output bit
// - SPI slave forces clock bit 5 input
// - SPI slave forces MOSI bit 4 input
// - SPI master forces MISO bit 2 input
// - Forced bit 2 pull-up follows output bit
// - Timer compare reaches bit 2 only if output
// - Three-wire data output replaces bit 2 value
// - Bit 2 pull-up kept under three-wire output
// - UART transmitter forces bit 1 output
// - LIN controller forces bit 1 output
// - Bit 1 input with output one pulls up
// - Reference output disables bit 7 driver, pull-up
// - External reference disables bit 7 driver, pull-up
// - Each pin feeds its pin-change source
// - Bit 3 feeds external interrupt source one
// - Pull-up override enable selects override value
// - Port and global pull-up disables ORed
// - UART/LIN receive forces bit 0 input
package paof_pkg;
	localparam int PAOF_WIDTH = 8;
	localparam int PAOF_BIT_RX = 0;
	localparam int PAOF_BIT_TX = 1;
	localparam int PAOF_BIT_MISO = 2;
	localparam int PAOF_BIT_EXT_IRQ = 3;
	localparam int PAOF_BIT_MOSI = 4;
	localparam int PAOF_BIT_SCK = 5;
	localparam int PAOF_BIT_SEL = 6;
	localparam int PAOF_BIT_REF = 7;
	localparam logic [7:0] PAOF_RESET_PINS = 8'h00;
	localparam logic PAOF_RESET_BIT = 1'b0;
endpackage

// *** logic/paof_port_a.sv ***
/*
 Port A alternate function override: builds per-pin override signals
 from peripheral enables and drives direction, value and pull-up.
 Assumes peripherals supply their own enable and output levels,
 synchronous to clk_sys_i; the pad resolves the wire from drive_en.
*/
`timescale 1ns/1ps
`default_nettype none
module paof_port_a
	import paof_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [7:0] dir_bits_i,
	input wire logic [7:0] outval_bits_i,
	input wire logic global_pullup_disable_i,
	input wire logic portwise_pullup_disable_i,
	input wire logic [7:0] pad_in_i,
	input wire logic spi_enable_i,
	input wire logic spi_master_i,
	input wire logic spi_sck_out_i,
	input wire logic spi_mosi_out_i,
	input wire logic spi_miso_out_i,
	input wire logic three_wire_do_en_i,
	input wire logic three_wire_do_i,
	input wire logic timer0_compare_out_a_en_i,
	input wire logic timer0_compare_out_a_i,
	input wire logic uart_tx_enable_i,
	input wire logic uart_tx_data_i,
	input wire logic uart_rx_enable_i,
	input wire logic lin_enable_i,
	input wire logic lin_transmit_i,
	input wire logic ref_out_en_i,
	input wire logic adc_ref_internal_i,
	input wire logic external_ref_in_use_i,
	output logic [7:0] pad_out_o,
	output logic [7:0] pad_oe_o,
	output logic [7:0] pullup_en_o,
	output logic [7:0] pin_level_o,
	output logic [7:0] pin_change_src_o,
	output logic ext_irq_src_1_o,
	output logic spi_slave_active_o,
	output logic internal_ref_output_o
);
	wire logic global_pullup_disable;
	wire logic spi_slave;
	wire logic spi_mst;
	wire logic tx_force;
	wire logic rx_force;
	wire logic ref_out;
	wire logic ref_block;
	wire logic [7:0] pullup_override_en;
	wire logic [7:0] pullup_override_val;
	wire logic [7:0] ddoe;
	wire logic [7:0] ddov;
	wire logic [7:0] pvoe;
	wire logic [7:0] pvov;
	wire logic [7:0] cell_en;
	wire logic [7:0] cell_val;
	wire logic [7:0] cell_pu;
	wire logic [7:0] next_oe;
	wire logic [7:0] next_pu;
	wire logic [7:0] sync_lvl;
	logic [7:0] pad_out;
	logic [7:0] pad_oe;
	logic [7:0] pullup_en;

	assign global_pullup_disable = global_pullup_disable_i | portwise_pullup_disable_i;
	assign spi_slave = spi_enable_i & ~spi_master_i;
	assign spi_mst = spi_enable_i & spi_master_i;
	assign tx_force = uart_tx_enable_i | lin_enable_i;
	assign rx_force = uart_rx_enable_i | lin_enable_i;
	// Reference only leaves the pin for the two internal voltages
	assign ref_out = ref_out_en_i & adc_ref_internal_i;
	assign ref_block = ref_out | external_ref_in_use_i;

	// Bit 0: receive forces input; pull-up stays with output bit
	assign ddoe[PAOF_BIT_RX] = rx_force;
	assign ddov[PAOF_BIT_RX] = 1'b0;
	assign pullup_override_en[PAOF_BIT_RX] = rx_force;
	assign pullup_override_val[PAOF_BIT_RX] = outval_bits_i[PAOF_BIT_RX] & ~global_pullup_disable;
	assign pvoe[PAOF_BIT_RX] = 1'b0;
	assign pvov[PAOF_BIT_RX] = 1'b0;

	// Bit 1: transmit forces output, pull-up off while driving
	assign ddoe[PAOF_BIT_TX] = tx_force;
	assign ddov[PAOF_BIT_TX] = 1'b1;
	assign pvoe[PAOF_BIT_TX] = tx_force;
	assign pvov[PAOF_BIT_TX] = lin_enable_i ? lin_transmit_i : uart_tx_data_i;
	assign pullup_override_en[PAOF_BIT_TX] = tx_force;
	assign pullup_override_val[PAOF_BIT_TX] = 1'b0;

	// Bit 2: SPI master forces input; value: SPI slave wins, then three-wire output, then timer
	assign ddoe[PAOF_BIT_MISO] = spi_mst;
	assign ddov[PAOF_BIT_MISO] = 1'b0;
	assign pullup_override_en[PAOF_BIT_MISO] = spi_mst;
	assign pullup_override_val[PAOF_BIT_MISO] = outval_bits_i[PAOF_BIT_MISO] & ~global_pullup_disable;
	// Value overrides leave direction alone; normal pull-up term holds
	assign pvoe[PAOF_BIT_MISO] = spi_slave | three_wire_do_en_i
		| timer0_compare_out_a_en_i;
	assign pvov[PAOF_BIT_MISO] = spi_slave ? spi_miso_out_i
		: (three_wire_do_en_i ? three_wire_do_i : timer0_compare_out_a_i);

	// Bit 3: plain port; feeds external interrupt
	assign ddoe[PAOF_BIT_EXT_IRQ] = 1'b0;
	assign ddov[PAOF_BIT_EXT_IRQ] = 1'b0;
	assign pullup_override_en[PAOF_BIT_EXT_IRQ] = 1'b0;
	assign pullup_override_val[PAOF_BIT_EXT_IRQ] = 1'b0;
	assign pvoe[PAOF_BIT_EXT_IRQ] = 1'b0;
	assign pvov[PAOF_BIT_EXT_IRQ] = 1'b0;

	// Bit 4: slave forces input; master drives MOSI if dir set
	// Three-wire data input overrides nothing, software owns dir
	assign ddoe[PAOF_BIT_MOSI] = spi_slave;
	assign ddov[PAOF_BIT_MOSI] = 1'b0;
	assign pullup_override_en[PAOF_BIT_MOSI] = spi_slave;
	assign pullup_override_val[PAOF_BIT_MOSI] = outval_bits_i[PAOF_BIT_MOSI] & ~global_pullup_disable;
	assign pvoe[PAOF_BIT_MOSI] = spi_mst;
	assign pvov[PAOF_BIT_MOSI] = spi_mosi_out_i;

	// Bit 5: slave forces input; master drives clock if dir set
	assign ddoe[PAOF_BIT_SCK] = spi_slave;
	assign ddov[PAOF_BIT_SCK] = 1'b0;
	assign pullup_override_en[PAOF_BIT_SCK] = spi_slave;
	assign pullup_override_val[PAOF_BIT_SCK] = outval_bits_i[PAOF_BIT_SCK] & ~global_pullup_disable;
	assign pvoe[PAOF_BIT_SCK] = spi_mst;
	assign pvov[PAOF_BIT_SCK] = spi_sck_out_i;

	// Bit 6: slave select, forced input in slave mode
	assign ddoe[PAOF_BIT_SEL] = spi_slave;
	assign ddov[PAOF_BIT_SEL] = 1'b0;
	assign pullup_override_en[PAOF_BIT_SEL] = spi_slave;
	assign pullup_override_val[PAOF_BIT_SEL] = outval_bits_i[PAOF_BIT_SEL] & ~global_pullup_disable;
	assign pvoe[PAOF_BIT_SEL] = 1'b0;
	assign pvov[PAOF_BIT_SEL] = 1'b0;

	// Bit 7: reference use kills driver and pull-up
	assign ddoe[PAOF_BIT_REF] = ref_block;
	assign ddov[PAOF_BIT_REF] = 1'b0;
	assign pullup_override_en[PAOF_BIT_REF] = ref_block;
	assign pullup_override_val[PAOF_BIT_REF] = 1'b0;
	assign pvoe[PAOF_BIT_REF] = 1'b0;
	assign pvov[PAOF_BIT_REF] = 1'b0;

	genvar gi;
	generate
		for (gi = 0; gi < PAOF_WIDTH; gi++)
		begin : g_cell
			paof_pin_cell u_cell (
				.dir_i(dir_bits_i[gi]),
				.outval_i(outval_bits_i[gi]),
				.pud_i(global_pullup_disable),
				.pullup_override_en_i(pullup_override_en[gi]),
				.pullup_override_val_i(pullup_override_val[gi]),
				.ddoe_i(ddoe[gi]),
				.ddov_i(ddov[gi]),
				.pvoe_i(pvoe[gi]),
				.pvov_i(pvov[gi]),
				.drive_en_o(cell_en[gi]),
				.drive_val_o(cell_val[gi]),
				.pullup_o(cell_pu[gi])
			);
		end
	endgenerate

	// A driven pin never pulls up at the same time
	assign next_oe = cell_en;
	assign next_pu = cell_pu & ~cell_en;

	// Registered pad controls cost one cycle but keep pads glitch-free
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			pad_out <= PAOF_RESET_PINS;
			pad_oe <= PAOF_RESET_PINS;
			pullup_en <= PAOF_RESET_PINS;
		end
		else
		begin
			pad_out <= cell_val;
			pad_oe <= next_oe;
			pullup_en <= next_pu;
		end
	end

	paof_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.pad_i(pad_in_i),
		.sync_o(sync_lvl)
	);

	logic slave_active;
	logic ref_flag;
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			slave_active <= PAOF_RESET_BIT;
			ref_flag <= PAOF_RESET_BIT;
		end
		else
		begin
			slave_active <= spi_slave & ~sync_lvl[PAOF_BIT_SEL];
			ref_flag <= ref_out;
		end
	end

	assign pad_out_o = pad_out;
	assign pad_oe_o = pad_oe;
	assign pullup_en_o = pullup_en;
	assign pin_level_o = sync_lvl;
	assign pin_change_src_o = sync_lvl;
	assign ext_irq_src_1_o = sync_lvl[PAOF_BIT_EXT_IRQ];
	assign spi_slave_active_o = slave_active;
	assign internal_ref_output_o = ref_flag;
endmodule
`default_nettype wire

// *** logic/paof_sync.sv ***
/*
 Two-flop synchroniser for the pin levels read back by the port.
 Assumes pad inputs are asynchronous to clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
module paof_sync
	import paof_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [7:0] pad_i,
	output logic [7:0] sync_o
);
	logic [7:0] stage1;
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			stage1 <= PAOF_RESET_PINS;
			sync_o <= PAOF_RESET_PINS;
		end
		else
		begin
			stage1 <= pad_i;
			sync_o <= stage1;
		end
	end
endmodule
`default_nettype wire

// *** tb/paof_periph.sv ***
/* Peripheral model: enables as the bench asks; data lines toggle
 every cycle so a stale value shows. Assumes clk_sys_i only. */
`timescale 1ns/1ps
`default_nettype none
module paof_periph
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [9:0] sel_i,
	output logic [9:0] en_o,
	output logic [6:0] dat_o
);
	assign en_o = sel_i;
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			dat_o <= 7'h55;
		else
			dat_o <= ~dat_o;
	end
endmodule
`default_nettype wire

// *** tb/paof_props.sv ***
/* Checker for paof_port_a pin controls.
 Bound to the top module; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module paof_props
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [7:0] dir_bits_i,
	input wire logic [7:0] outval_bits_i,
	input wire logic global_pullup_disable_i,
	input wire logic portwise_pullup_disable_i,
	input wire logic [7:0] pad_in_i,
	input wire logic spi_enable_i,
	input wire logic spi_master_i,
	input wire logic uart_tx_enable_i,
	input wire logic uart_rx_enable_i,
	input wire logic lin_enable_i,
	input wire logic lin_transmit_i,
	input wire logic ref_out_en_i,
	input wire logic adc_ref_internal_i,
	input wire logic external_ref_in_use_i,
	input wire logic [7:0] pad_out_o,
	input wire logic [7:0] pad_oe_o,
	input wire logic [7:0] pullup_en_o,
	input wire logic [7:0] pin_change_src_o,
	input wire logic ext_irq_src_1_o,
	input wire logic [7:0] pin_level_o,
	input wire logic spi_slave_active_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire logic slv = spi_enable_i & ~spi_master_i;
	wire logic global_pullup_disable = global_pullup_disable_i | portwise_pullup_disable_i;
	slave_in_a: assert property (slv |=> pad_oe_o[6:4] == 3'h0)
		else $error("slave SPI pin driven");
	miso_in_a: assert property (spi_enable_i & spi_master_i |=> !pad_oe_o[2])
		else $error("MISO driven as master");
	bit2_dir_a: assert property (!(spi_enable_i & spi_master_i)
		|=> pad_oe_o[2] == $past(dir_bits_i[2])) else $error("bit 2 drive wrong");
	tx_out_a: assert property (uart_tx_enable_i | lin_enable_i |=> pad_oe_o[1])
		else $error("bit 1 not driven");
	lin_val_a: assert property (lin_enable_i |=> pad_out_o[1] == $past(lin_transmit_i))
		else $error("bit 1 value wrong");
	rx_in_a: assert property (uart_rx_enable_i | lin_enable_i |=> !pad_oe_o[0])
		else $error("bit 0 driven");
	ref_off_a: assert property (ref_out_en_i & adc_ref_internal_i | external_ref_in_use_i
		|=> !pad_oe_o[7] && !pullup_en_o[7]) else $error("bit 7 not released");
	plain_bit_a: assert property (1 |=> pad_oe_o[3] == $past(dir_bits_i[3])
		&& pullup_en_o[3] == $past(!dir_bits_i[3] & outval_bits_i[3] & !global_pullup_disable))
		else $error("bit 3 ordinary path wrong");
	pin_src_a: assert property ($stable(pad_in_i)[*4] |=> pin_change_src_o == $past(pad_in_i)
		&& ext_irq_src_1_o == $past(pad_in_i[3])) else $error("pin sources wrong");
	slave_pu_a: assert property (slv
		|=> pullup_en_o[6:4] == $past(outval_bits_i[6:4] & {3{!global_pullup_disable}}))
		else $error("slave SPI pull-up wrong");
	master_pu_a: assert property (spi_enable_i & spi_master_i
		|=> pullup_en_o[2] == $past(outval_bits_i[2] & !global_pullup_disable))
		else $error("MISO pull-up wrong");
	slave_act_a: assert property (1
		|=> spi_slave_active_o == $past(slv & !pin_level_o[6]))
		else $error("slave active wrong");
	cover property (slv ##1 slv);
	cover property (lin_enable_i);
	cover property (ref_out_en_i & adc_ref_internal_i);
	cover property (spi_slave_active_o);
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/* Bench for paof_port_a: sets port bits and peripheral enables,
 compares pin controls. Assumes the checker and model files. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys_i = 0;
	logic rst_i = 1;
	logic [7:0] dir = 8'h00;
	logic [7:0] ov = 8'h00;
	logic [1:0] global_pullup_disable = 2'h0;
	logic [7:0] pad = 8'h00;
	logic [9:0] sel = 10'h000;
	wire logic [9:0] en;
	wire logic [6:0] dat;
	logic [7:0] oe, po, pu, pcs, lvl;
	logic irq, sact, rflag;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	int tno = 0;
	initial
	begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 500)
		begin
			n_fail++;
			tally_and_finish();
		end
	end
	paof_periph u_per (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sel_i(sel), .en_o(en), .dat_o(dat));
	paof_port_a DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .dir_bits_i(dir),
		.outval_bits_i(ov), .global_pullup_disable_i(global_pullup_disable[0]),
		.portwise_pullup_disable_i(global_pullup_disable[1]), .pad_in_i(pad),
		.spi_enable_i(en[0]), .spi_master_i(en[1]), .spi_sck_out_i(dat[0]),
		.spi_mosi_out_i(dat[1]), .spi_miso_out_i(dat[2]), .three_wire_do_en_i(en[2]),
		.three_wire_do_i(dat[3]), .timer0_compare_out_a_en_i(en[3]),
		.timer0_compare_out_a_i(dat[4]), .uart_tx_enable_i(en[4]), .uart_tx_data_i(dat[5]),
		.uart_rx_enable_i(en[5]), .lin_enable_i(en[6]), .lin_transmit_i(dat[6]),
		.ref_out_en_i(en[7]), .adc_ref_internal_i(en[8]), .external_ref_in_use_i(en[9]),
		.pad_out_o(po), .pad_oe_o(oe), .pullup_en_o(pu), .pin_level_o(lvl),
		.pin_change_src_o(pcs), .ext_irq_src_1_o(irq), .spi_slave_active_o(sact),
		.internal_ref_output_o(rflag));
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	// Controls land one edge late; two edges leave margin
	task automatic v(input logic [9:0] s, input logic [7:0] d, input logic [7:0] o,
		input logic [1:0] p, input logic [7:0] eo, input logic [7:0] ep);
		sel = s;
		dir = d;
		ov = o;
		global_pullup_disable = p;
		step(2);
		cmp(oe, eo);
		cmp(pu, ep);
		tno++;
		$display("test %0d done", tno);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		step(3);
		rst_i = 0;
		v(10'h000, 8'h0f, 8'hf0, 2'h0, 8'h0f, 8'hf0);
		cmp(po, 8'hf0);
		v(10'h001, 8'hff, 8'hff, 2'h0, 8'h8f, 8'h70);
		v(10'h001, 8'h04, 8'h00, 2'h0, 8'h04, 8'h00);
		cmp(po & 8'h04, {5'h0, ~dat[2], 2'h0});
		v(10'h003, 8'hff, 8'hff, 2'h0, 8'hfb, 8'h04);
		v(10'h003, 8'h30, 8'h00, 2'h0, 8'h30, 8'h00);
		cmp(po & 8'h30, {2'h0, ~dat[0], ~dat[1], 4'h0});
		// Three-wire data input: software keeps bit 4 an input
		v(10'h000, 8'hef, 8'h10, 2'h0, 8'hef, 8'h10);
		v(10'h004, 8'h00, 8'h04, 2'h0, 8'h00, 8'h04);
		// Data toggles each cycle: the pin shows last cycle's value
		v(10'h008, 8'h04, 8'h00, 2'h0, 8'h04, 8'h00);
		cmp(po & 8'h04, {5'h0, ~dat[4], 2'h0});
		v(10'h00c, 8'h04, 8'h00, 2'h0, 8'h04, 8'h00);
		cmp(po & 8'h04, {5'h0, ~dat[3], 2'h0});
		v(10'h010, 8'h00, 8'h02, 2'h0, 8'h02, 8'h00);
		cmp(po & 8'h02, {6'h0, ~dat[5], 1'h0});
		v(10'h040, 8'hff, 8'hff, 2'h0, 8'hfe, 8'h01);
		cmp(po & 8'h02, {6'h0, ~dat[6], 1'h0});
		v(10'h020, 8'h01, 8'h03, 2'h0, 8'h00, 8'h03);
		v(10'h180, 8'h80, 8'h80, 2'h0, 8'h00, 8'h00);
		cmp({7'h0, rflag}, 8'h01);
		v(10'h080, 8'h80, 8'h80, 2'h0, 8'h80, 8'h00);
		cmp({7'h0, rflag}, 8'h00);
		v(10'h200, 8'h00, 8'h80, 2'h0, 8'h00, 8'h00);
		v(10'h000, 8'h00, 8'hff, 2'h1, 8'h00, 8'h00);
		v(10'h000, 8'h00, 8'hff, 2'h2, 8'h00, 8'h00);
		v(10'h001, 8'h00, 8'h00, 2'h0, 8'h00, 8'h00);
		pad = 8'ha5;
		step(4);
		cmp(pcs, 8'ha5);
		cmp(lvl, 8'ha5);
		cmp({7'h0, irq}, 8'h00);
		cmp({7'h0, sact}, 8'h01);
		pad = 8'h5a;
		step(4);
		cmp(pcs, 8'h5a);
		cmp(lvl, 8'h5a);
		cmp({7'h0, irq}, 8'h01);
		cmp({7'h0, sact}, 8'h00);
		tally_and_finish();
	end
endmodule
bind paof_port_a paof_props u_props (
	.clk_sys_i(clk_sys_i),
	.rst_i(rst_i),
	.dir_bits_i(dir_bits_i),
	.outval_bits_i(outval_bits_i),
	.global_pullup_disable_i(global_pullup_disable_i),
	.portwise_pullup_disable_i(portwise_pullup_disable_i),
	.pad_in_i(pad_in_i),
	.spi_enable_i(spi_enable_i),
	.spi_master_i(spi_master_i),
	.uart_tx_enable_i(uart_tx_enable_i),
	.uart_rx_enable_i(uart_rx_enable_i),
	.lin_enable_i(lin_enable_i),
	.lin_transmit_i(lin_transmit_i),
	.ref_out_en_i(ref_out_en_i),
	.adc_ref_internal_i(adc_ref_internal_i),
	.external_ref_in_use_i(external_ref_in_use_i),
	.pad_out_o(pad_out_o),
	.pad_oe_o(pad_oe_o),
	.pullup_en_o(pullup_en_o),
	.pin_change_src_o(pin_change_src_o),
	.ext_irq_src_1_o(ext_irq_src_1_o),
	.pin_level_o(pin_level_o),
	.spi_slave_active_o(spi_slave_active_o)
);
`default_nettype wire
